// ---- hw/ssrx_device.sv ----
// Synchronous half-duplex receive path: master and slave clocking, 2-deep FIFO
//
// Functional notes
// R1: Master receive: data pin driver off, input.
// R2: Single or continuous enable starts reception.
// R3: Single mode: one character's clocks, then clear.
// R4: Continuous mode: clocks run until enable cleared.
// R5: Continuous cleared mid-character: clock stops, bits dropped.
// R6: Both enables: single clears after first character.
// R7: Sample data on trailing clock edge, shift.
// R8: Full character sets pending, enters 2-entry FIFO.
// R9: Data shows oldest entry; pending while unread.
// R10: Slave mode: clock driver off, external clock.
// R11: Data changes leading edge, one bit per cycle.
// R12: External master gives exactly one character's clocks.
// R13: Third character with full FIFO sets overrun.
// R14: Overrun keeps entries readable, blocks reception.
// R15: Single-mode overrun cleared by data read.
// R16: Continuous overrun cleared by disabling; port off resets.
// R17: Nine-bit select shifts nine bits per character.
// R18: Ninth bit shows MSB of oldest entry.
// R19: Software reads ninth bit before data.
// R20: Software configures before enabling reception.
// R21: Pending with interrupt enable raises request.
// R22: Polarity bit selects idle level and edges.
// R23: Clock source bit makes device drive clock.
// R24: Master bit clock from divisor, idle otherwise.
`timescale 1ns/1ps
`default_nettype none
module ssrx_device
  import ssrx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic serial_port_on_i,
  input wire logic clock_source_master_i,
  input wire logic clock_idle_polarity_i,
  input wire logic nine_bit_receive_select_i,
  input wire logic single_receive_enable_set_i,
  input wire logic single_receive_enable_clr_i,
  input wire logic continuous_receive_enable_i,
  input wire logic receive_irq_enable_i,
  input wire logic [SSRX_DIV_W-1:0] baud_divisor_i,
  input wire logic rx_data_read_i,
  ssrx_link_if.dev link,
  output logic [7:0] rx_data_o,
  output logic ninth_received_bit_o,
  output logic receive_pending_flag_o,
  output logic overrun_error_flag_o,
  output logic single_receive_enable_o,
  output logic irq_o
);

  logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
  logic dt_s1_ff, dt_s2_ff;
  logic single_receive_enable_ff, overrun_error_flag_ff, overrun_error_flag_single_ff;
  logic [SSRX_DIV_W-1:0] div_cnt_ff;
  logic half_ff;
  logic [3:0] bit_cnt_ff;
  logic [SSRX_WORD_W-1:0] rsr_ff;
  logic [SSRX_WORD_W-1:0] slot0_ff, slot1_ff;
  logic [1:0] cnt_ff;
  logic pending_ff, irq_ff, ck_out_ff, ck_oe_ff;

  // Two-flop synchronisers on link pins, third stage for edge finding
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      // Pulled-up idle level, so no false edge follows reset
      ck_s1_ff <= SSRX_LINK_IDLE;
      ck_s2_ff <= SSRX_LINK_IDLE;
      ck_s3_ff <= SSRX_LINK_IDLE;
      dt_s1_ff <= SSRX_LINK_IDLE;
      dt_s2_ff <= SSRX_LINK_IDLE;
    end else begin
      ck_s1_ff <= link.ck;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
      dt_s1_ff <= link.dt;
      dt_s2_ff <= dt_s1_ff;
    end
  end

  // Slave trailing edge: falling when idle low, rising when idle high
  wire ck_rise = ~ck_s3_ff & ck_s2_ff;
  wire ck_fall = ck_s3_ff & ~ck_s2_ff;
  wire slave_trail = clock_idle_polarity_i ? ck_rise : ck_fall; // [R22]

  // Receive enable decode
  wire is_master = clock_source_master_i; // [R23]
  wire any_en = single_receive_enable_ff | continuous_receive_enable_i; // [R2]
  wire slave_en = continuous_receive_enable_i; // single enable ignored
  wire rx_enable = serial_port_on_i & (is_master ? any_en : slave_en);
  wire rx_active = rx_enable & ~overrun_error_flag_ff; // [R14]
  wire run_m = rx_active & is_master;

  // Master bit clock from divisor ticks, two ticks per bit
  wire div_tick = (div_cnt_ff == baud_divisor_i); // [R24]
  wire m_sample = run_m & div_tick & ~half_ff; // [R7]
  wire s_sample = rx_active & ~is_master & slave_trail; // [R7] [R10] [R12]
  wire sample = m_sample | s_sample;
  wire [SSRX_DIV_W-1:0] nxt_div_cnt =
    (!run_m || div_tick) ? SSRX_RST_DIV : div_cnt_ff + 16'h0001;
  wire nxt_half = run_m ? (half_ff ^ div_tick) : SSRX_RST_BIT;

  // Character assembly, LSB first
  wire [3:0] last_idx =
    nine_bit_receive_select_i ? SSRX_LAST_IDX_9 : SSRX_LAST_IDX_8; // [R17]
  wire char_done = sample & (bit_cnt_ff == last_idx);
  wire [SSRX_WORD_W-1:0] new_word = nine_bit_receive_select_i ?
    {dt_s2_ff, rsr_ff[7:0]} : {1'b0, dt_s2_ff, rsr_ff[6:0]};
  wire [3:0] nxt_bit_cnt = (!rx_active || char_done) ? SSRX_RST_IDX : // [R5]
    (sample ? bit_cnt_ff + 4'd1 : bit_cnt_ff);

  // FIFO push, pop and overrun decode
  wire pop = rx_data_read_i & (cnt_ff != SSRX_RST_CNT);
  wire room = (cnt_ff < SSRX_FIFO_DEPTH) | pop;
  wire push = char_done & room; // [R8]
  wire ovr_evt = char_done & ~room; // [R13]
  wire [1:0] nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});

  // Overrun clear terms
  wire clr_single = overrun_error_flag_single_ff & rx_data_read_i; // [R15]
  wire clr_cont = ~overrun_error_flag_single_ff & ~continuous_receive_enable_i; // [R16]
  wire nxt_overrun_error_flag = ovr_evt | (overrun_error_flag_ff & ~clr_single & ~clr_cont);

  // Single enable: software set wins over the self-clear
  wire single_receive_enable_clr = single_receive_enable_clr_i | char_done; // [R3] [R6]
  wire nxt_single_receive_enable = single_receive_enable_set_i | (single_receive_enable_ff & ~single_receive_enable_clr);

  // Master divider and half-bit phase
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      div_cnt_ff <= SSRX_RST_DIV;
      half_ff <= SSRX_RST_BIT;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      half_ff <= nxt_half; // [R4]
    end
  end

  // Shift register and bit counter
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      bit_cnt_ff <= SSRX_RST_IDX;
      rsr_ff <= SSRX_RST_WORD;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt; // [R11]
      if (sample) begin
        rsr_ff[bit_cnt_ff] <= dt_s2_ff; // [R7]
      end
    end
  end

  // Control flags; port off clears them, as it does the FIFO and status
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !serial_port_on_i) begin
      single_receive_enable_ff <= SSRX_RST_BIT;
      overrun_error_flag_ff <= SSRX_RST_BIT;
      overrun_error_flag_single_ff <= SSRX_RST_BIT;
    end else begin
      single_receive_enable_ff <= nxt_single_receive_enable;
      overrun_error_flag_ff <= nxt_overrun_error_flag; // [R13] [R16]
      if (ovr_evt) begin
        overrun_error_flag_single_ff <= single_receive_enable_ff & ~continuous_receive_enable_i;
      end
    end
  end

  // Two-entry FIFO, slot0 always the oldest
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !serial_port_on_i) begin
      slot0_ff <= SSRX_RST_WORD;
      slot1_ff <= SSRX_RST_WORD;
      cnt_ff <= SSRX_RST_CNT;
    end else begin
      cnt_ff <= nxt_cnt;
      case ({push, pop})
        2'b10: begin
          if (cnt_ff == SSRX_RST_CNT) begin
            slot0_ff <= new_word;
          end else begin
            slot1_ff <= new_word;
          end
        end
        2'b01: begin
          slot0_ff <= slot1_ff; // [R9]
        end
        2'b11: begin
          if (cnt_ff == SSRX_FIFO_DEPTH) begin
            slot0_ff <= slot1_ff;
            slot1_ff <= new_word;
          end else begin
            slot0_ff <= new_word;
          end
        end
        default: begin
          slot0_ff <= slot0_ff; // [R14]
        end
      endcase
    end
  end

  // Status, interrupt and link clock outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pending_ff <= SSRX_RST_BIT;
      irq_ff <= SSRX_RST_BIT;
      ck_out_ff <= SSRX_RST_BIT;
      ck_oe_ff <= SSRX_RST_BIT;
    end else begin
      pending_ff <= serial_port_on_i & (nxt_cnt != SSRX_RST_CNT); // [R8] [R9]
      irq_ff <= serial_port_on_i & receive_irq_enable_i &
                (nxt_cnt != SSRX_RST_CNT); // [R21]
      ck_out_ff <= clock_idle_polarity_i ^ (run_m & ~half_ff); // [R22] [R24]
      ck_oe_ff <= serial_port_on_i & is_master; // [R10] [R23]
    end
  end

  // Receive path never drives the data pin
  assign link.dev_dt_o = SSRX_RST_BIT;
  assign link.dev_dt_oe = SSRX_RST_BIT; // [R1]
  assign link.dev_ck_o = ck_out_ff;
  assign link.dev_ck_oe = ck_oe_ff;

  // User-side outputs, all from flops
  assign rx_data_o = slot0_ff[7:0]; // [R9] [R19]
  assign ninth_received_bit_o = slot0_ff[8]; // [R18]
  assign receive_pending_flag_o = pending_ff;
  assign overrun_error_flag_o = overrun_error_flag_ff;
  assign single_receive_enable_o = single_receive_enable_ff;
  assign irq_o = irq_ff;

endmodule : ssrx_device
`default_nettype wire

// ---- hw/ssrx_pkg.sv ----
// Shared constants for the synchronous serial receive path and its partner
package ssrx_pkg;
  // Receive FIFO and character layout
  localparam logic [1:0] SSRX_FIFO_DEPTH = 2'd2;
  localparam logic [3:0] SSRX_LAST_IDX_8 = 4'd7;
  localparam logic [3:0] SSRX_LAST_IDX_9 = 4'd8;
  localparam int SSRX_WORD_W = 9;
  localparam int SSRX_DIV_W = 16;
  // Values after reset
  localparam logic SSRX_RST_BIT = 1'b0;
  localparam logic [8:0] SSRX_RST_WORD = 9'h000;
  localparam logic [1:0] SSRX_RST_CNT = 2'd0;
  localparam logic [3:0] SSRX_RST_IDX = 4'd0;
  localparam logic [15:0] SSRX_RST_DIV = 16'h0000;
  // Partner bit clock half period in system clocks (80 ns period)
  localparam logic [15:0] SSRX_PART_HALF_CYC = 16'h0004;
  // Idle level of an undriven link wire
  localparam logic SSRX_LINK_IDLE = 1'b1;
endpackage : ssrx_pkg

// ---- hw/ssrx_link_if.sv ----
// Link between the receive path and its serial partner
`timescale 1ns/1ps
`default_nettype none
interface ssrx_link_if;
  import ssrx_pkg::*;
  // Drivers and enables of each end
  logic dev_ck_o;
  logic dev_ck_oe;
  logic dev_dt_o;
  logic dev_dt_oe;
  logic par_ck_o;
  logic par_ck_oe;
  logic par_dt_o;
  logic par_dt_oe;
  // Resolved wire levels, pulled up when nobody drives
  logic ck;
  logic dt;
  assign ck = dev_ck_oe ? dev_ck_o : (par_ck_oe ? par_ck_o : SSRX_LINK_IDLE);
  assign dt = dev_dt_oe ? dev_dt_o : (par_dt_oe ? par_dt_o : SSRX_LINK_IDLE);

  modport dev (
    input ck,
    input dt,
    output dev_ck_o,
    output dev_ck_oe,
    output dev_dt_o,
    output dev_dt_oe
  );

  modport par (
    input ck,
    input dt,
    output par_ck_o,
    output par_ck_oe,
    output par_dt_o,
    output par_dt_oe
  );
endinterface : ssrx_link_if
`default_nettype wire

// ---- hw/ssrx_partner.sv ----
// Serial partner: data source as slave or clocking master for the receive path
`timescale 1ns/1ps
`default_nettype none
module ssrx_partner
  import ssrx_pkg::*;
#(
  parameter logic [15:0] HALF_CYC = SSRX_PART_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic part_enable_i,
  input wire logic part_master_i,
  input wire logic clock_idle_polarity_i,
  input wire logic nine_bit_i,
  input wire logic [SSRX_WORD_W-1:0] tx_word_i,
  input wire logic tx_start_i,
  ssrx_link_if.par link,
  output logic tx_taken_o,
  output logic busy_o
);

  logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
  logic run_ff, ph_ff;
  logic [15:0] hc_ff;
  logic [3:0] bit_cnt_ff;
  logic [SSRX_WORD_W-1:0] word_ff;
  logic dt_ff, ck_ff, ck_oe_ff, dt_oe_ff, taken_ff;

  // Clock pin synchroniser, third stage for edge finding
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      // Pulled-up idle level, so no false edge follows reset
      ck_s1_ff <= SSRX_LINK_IDLE;
      ck_s2_ff <= SSRX_LINK_IDLE;
      ck_s3_ff <= SSRX_LINK_IDLE;
    end else begin
      ck_s1_ff <= link.ck;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
    end
  end

  // Leading edge: rising when idle low, falling when idle high
  wire ck_rise = ~ck_s3_ff & ck_s2_ff;
  wire ck_fall = ck_s3_ff & ~ck_s2_ff;
  wire s_lead = part_enable_i & ~part_master_i &
    (clock_idle_polarity_i ? ck_fall : ck_rise);

  // Own bit clock when master: exactly one character of cycles
  wire [3:0] last_idx = nine_bit_i ? SSRX_LAST_IDX_9 : SSRX_LAST_IDX_8;
  wire hc_end = run_ff & (hc_ff == HALF_CYC - 16'h0001);
  wire m_first = part_enable_i & part_master_i & tx_start_i & ~run_ff;
  wire m_next = hc_end & ph_ff & (bit_cnt_ff != SSRX_RST_IDX);
  wire m_stop = hc_end & ph_ff & (bit_cnt_ff == SSRX_RST_IDX);
  // Next clock state, so leading edge and data change share one edge
  wire nxt_run = m_first | (run_ff & ~m_stop);
  wire nxt_ph = m_first ? SSRX_RST_BIT : (ph_ff ^ hc_end);
  wire ck_act = part_enable_i & part_master_i & nxt_run & ~nxt_ph;
  wire lead = s_lead | m_first | m_next;
  wire first_bit = (bit_cnt_ff == SSRX_RST_IDX);
  wire [SSRX_WORD_W-1:0] cur_word = first_bit ? tx_word_i : word_ff;
  wire [3:0] nxt_bit_cnt = (bit_cnt_ff == last_idx) ? SSRX_RST_IDX :
    bit_cnt_ff + 4'd1;

  // Master clock generator
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !part_enable_i || !part_master_i) begin
      run_ff <= SSRX_RST_BIT;
      ph_ff <= SSRX_RST_BIT;
      hc_ff <= SSRX_RST_DIV;
    end else begin
      if (m_first) begin
        run_ff <= 1'b1;
      end else if (m_stop) begin
        run_ff <= SSRX_RST_BIT;
      end
      hc_ff <= (m_first || hc_end) ? SSRX_RST_DIV : hc_ff + 16'h0001;
      if (m_first) begin
        ph_ff <= SSRX_RST_BIT;
      end else if (hc_end) begin
        ph_ff <= ~ph_ff;
      end
    end
  end

  // Data changes on each leading edge, one bit per cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !part_enable_i) begin
      bit_cnt_ff <= SSRX_RST_IDX;
      word_ff <= SSRX_RST_WORD;
      dt_ff <= SSRX_RST_BIT;
      taken_ff <= SSRX_RST_BIT;
    end else begin
      taken_ff <= lead & first_bit;
      if (lead) begin
        dt_ff <= cur_word[bit_cnt_ff]; // [R11]
        bit_cnt_ff <= nxt_bit_cnt;
        if (first_bit) begin
          word_ff <= tx_word_i;
        end
      end
    end
  end

  // Pin drivers: clock only as master, data whenever enabled
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ck_ff <= SSRX_RST_BIT;
      ck_oe_ff <= SSRX_RST_BIT;
      dt_oe_ff <= SSRX_RST_BIT;
    end else begin
      ck_ff <= clock_idle_polarity_i ^ ck_act; // [R11] [R12]
      ck_oe_ff <= part_enable_i & part_master_i;
      dt_oe_ff <= part_enable_i;
    end
  end

  assign link.par_ck_o = ck_ff;
  assign link.par_ck_oe = ck_oe_ff;
  assign link.par_dt_o = dt_ff;
  assign link.par_dt_oe = dt_oe_ff;
  assign tx_taken_o = taken_ff;
  assign busy_o = run_ff;

endmodule : ssrx_partner
`default_nettype wire

// ---- sim/ssrx_link_monitor.sv ----
// Wire checks between the receive path and its partner
`timescale 1ns/1ps
`default_nettype none
module ssrx_link_monitor (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic dev_dt_oe,
  input wire logic dev_ck_oe,
  input wire logic par_ck_oe,
  input wire logic par_dt_oe,
  input wire logic par_dt_o,
  input wire logic ck,
  input wire logic dt
);
  logic ck_ff;
  logic oe_ff;
  logic [4:0] quiet_ff;
  logic [4:0] edges_ff;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Previous clock wire level and partner clock driver enable
  always_ff @(posedge sys_clk_i) begin
    ck_ff <= ck;
    oe_ff <= par_ck_oe;
  end
  // Partner clock edges per burst, a quiet spell ends the burst
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      quiet_ff <= 5'h00;
      edges_ff <= 5'h00;
    end else if (par_ck_oe && oe_ff && ck != ck_ff) begin
      quiet_ff <= 5'h00;
      edges_ff <= edges_ff + 5'h01;
    end else begin
      if (quiet_ff != 5'h1f) begin
        quiet_ff <= quiet_ff + 5'h01;
      end
      // Burst closed once the spell is judged, count starts afresh
      if (quiet_ff == 5'h08) begin
        edges_ff <= 5'h00;
      end
    end
  end
  sequence s_burst_over;
    quiet_ff == 5'h08 && edges_ff != 5'h00;
  endsequence
  sequence s_par_edge;
    par_ck_oe && $past(par_ck_oe) && $changed(ck);
  endsequence
  chk_dt_drv_off: assert property (!dev_dt_oe)
    else $error("device drives data");
  chk_ck_one_drv: assert property (!(dev_ck_oe && par_ck_oe))
    else $error("two clock drivers");
  chk_dt_from_par: assert property (par_dt_oe |-> dt == par_dt_o)
    else $error("data wire not from partner");
  chk_dt_lead: assert property (par_dt_oe && $past(par_dt_oe)
    && $changed(dt) |=> $stable(ck)[*2]) else $error("data late");
  chk_par_half: assert property (s_par_edge
    |=> ($stable(ck) || !par_ck_oe)[*3]) else $error("short half");
  chk_dev_half: assert property (dev_ck_oe && $past(dev_ck_oe)
    && $changed(ck) |=> $stable(ck)[*3]) else $error("short half");
  chk_burst_len: assert property (s_burst_over
    |-> edges_ff >= 5'd15 && edges_ff <= 5'd18) else $error("bad count");
  chk_burst_steady: assert property (edges_ff != 5'h00
    && edges_ff < 5'd15 |-> quiet_ff < 5'd6) else $error("gap in burst");
endmodule : ssrx_link_monitor
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the receive path facing its partner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssrx_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic on = 1'b0, mst = 1'b0, pol = 1'b0, nine = 1'b0, sset = 1'b0;
  logic continuous_receive_enable = 1'b0, irqen = 1'b0, rd = 1'b0, pen = 1'b0, pmst = 1'b0;
  logic pstart = 1'b0, ck_q = 1'b1;
  logic [15:0] div = 16'h0007;
  logic [8:0] word = 9'h155;
  logic [31:0] lfsr = 32'd96069;
  logic [7:0] data;
  logic ninth, pend, ovr, single_receive_enable, irq, taken, pbusy;
  int bad_count = 0;
  int checks = 0;
  int trails = 0;
  logic [8:0] sent[$];
  ssrx_link_if link ();
  ssrx_device u_ssrx_device (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .serial_port_on_i(on), .clock_source_master_i(mst),
    .clock_idle_polarity_i(pol), .nine_bit_receive_select_i(nine),
    .single_receive_enable_set_i(sset), .single_receive_enable_clr_i(1'b0),
    .continuous_receive_enable_i(continuous_receive_enable), .receive_irq_enable_i(irqen),
    .baud_divisor_i(div), .rx_data_read_i(rd), .link(link.dev),
    .rx_data_o(data), .ninth_received_bit_o(ninth),
    .receive_pending_flag_o(pend), .overrun_error_flag_o(ovr),
    .single_receive_enable_o(single_receive_enable), .irq_o(irq));
  ssrx_partner u_ssrx_partner (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .part_enable_i(pen), .part_master_i(pmst), .clock_idle_polarity_i(pol),
    .nine_bit_i(nine), .tx_word_i(word), .tx_start_i(pstart),
    .link(link.par), .tx_taken_o(taken), .busy_o(pbusy));
  ssrx_link_monitor u_mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .dev_dt_oe(link.dev_dt_oe), .dev_ck_oe(link.dev_ck_oe),
    .par_ck_oe(link.par_ck_oe), .par_dt_oe(link.par_dt_oe),
    .par_dt_o(link.par_dt_o), .ck(link.ck), .dt(link.dt));
  always #5 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  // Expected entry: bit 8 is zero for eight-bit characters
  function automatic logic [8:0] exp_word(input logic [8:0] w);
    return nine ? w : {1'b0, w[7:0]};
  endfunction : exp_word
  // Fresh random word once the partner has taken one
  always @(negedge sys_clk_i) begin
    if (taken === 1'b1) begin
      sent.push_back(exp_word(word));
      lfsr = nxt_rand(lfsr);
      word <= lfsr[8:0];
    end
  end
  // Trailing edges, towards idle, while the device drives the clock
  always @(posedge sys_clk_i) begin
    ck_q <= link.ck;
    if (link.dev_ck_oe && ck_q !== link.ck && link.ck === pol) trails++;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick
  task automatic check(input string s, input logic [8:0] e,
                       input logic [8:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Bounded wait: 0 pending, 1 partner busy, 2 single enable
  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (n < 4000 && (w == 0 ? pend : w == 1 ? pbusy : single_receive_enable) !== v) begin
      tick(1);
      n++;
    end
    if (n == 4000) begin
      check("wait", {8'h00, v}, {8'h00, ~v});
      print_verdict();
    end
  endtask : wait_for
  // One-cycle strobe: 0 single set, 1 data read, 2 partner start
  task automatic pulse(input int w);
    {sset, rd, pstart} = 3'b100 >> w;
    tick(1);
    {sset, rd, pstart} = 3'b000;
    tick(1);
  endtask : pulse
  task automatic pop_chk();
    logic [8:0] e;
    wait_for(0, 1'b1);
    e = sent.pop_front();
    check("word", e, {ninth, data});
    check("irq", {8'h00, irqen}, {8'h00, irq});
    pulse(1);
  endtask : pop_chk
  task automatic send();
    pulse(2);
    wait_for(1, 1'b0);
    tick(8);
  endtask : send
  // Stop continuous receive just after a trailing edge
  task automatic halt();
    trails = 0;
    for (int n = 0; n < 400 && trails < 3; n++) tick(1);
    if (trails < 3) begin
      check("halt", 9'h003, 9'(trails));
      print_verdict();
    end
    continuous_receive_enable = 1'b0;
  endtask : halt
  // Port off, random polarity, width, irq enable and divisor, port on
  task automatic setup(input logic m);
    on = 1'b0;
    pen = 1'b0;
    continuous_receive_enable = 1'b0;
    // Let the release edge of the clock wire pass the synchronisers
    tick(4);
    sent.delete();
    lfsr = nxt_rand(lfsr);
    {pol, nine, irqen} = lfsr[2:0];
    div = {13'h0000, lfsr[5:3]} + 16'h0007;
    mst = m;
    pmst = ~m;
    pen = 1'b1;
    on = 1'b1;
    tick(4);
  endtask : setup
  initial begin
    tick(16);
    rstn_i = 1'b1;
    repeat (6) begin
      setup(1'b0);
      continuous_receive_enable = 1'b1;
      send();
      pop_chk();
    end
    $display("slave receive done");
    setup(1'b0);
    continuous_receive_enable = 1'b1;
    repeat (4) send();
    check("ovr", 9'h001, {8'h00, ovr});
    void'(sent.pop_back());
    void'(sent.pop_back());
    pop_chk();
    pop_chk();
    tick(2);
    check("ovr pend", 9'h002, {7'h00, ovr, pend});
    continuous_receive_enable = 1'b0;
    tick(3);
    check("ovr", 9'h000, {8'h00, ovr});
    continuous_receive_enable = 1'b1;
    repeat (3) send();
    check("ovr pend", 9'h003, {7'h00, ovr, pend});
    on = 1'b0;
    tick(3);
    check("off", 9'h000, {7'h00, ovr, pend});
    $display("overrun continuous done");
    repeat (4) begin
      setup(1'b1);
      trails = 0;
      pulse(0);
      check("single_receive_enable", 9'h001, {8'h00, single_receive_enable});
      pop_chk();
      tick(4);
      check("clocks", nine ? 9'h009 : 9'h008, 9'(trails));
      check("single_receive_enable", 9'h000, {8'h00, single_receive_enable});
      check("idle", {8'h00, pol}, {8'h00, link.ck});
    end
    $display("master single done");
    setup(1'b1);
    continuous_receive_enable = 1'b1;
    pop_chk();
    pop_chk();
    halt();
    tick(300);
    check("part", 9'h003, 9'(trails));
    check("drop", 9'h000, {8'h00, pend});
    check("idle", {8'h00, pol}, {8'h00, link.ck});
    $display("master continuous done");
    setup(1'b1);
    continuous_receive_enable = 1'b1;
    pulse(0);
    pop_chk();
    check("single_receive_enable", 9'h000, {8'h00, single_receive_enable});
    pop_chk();
    halt();
    $display("both enables done");
    setup(1'b1);
    repeat (3) begin
      pulse(0);
      wait_for(2, 1'b0);
      tick(4);
    end
    check("ovr", 9'h001, {8'h00, ovr});
    void'(sent.pop_back());
    pop_chk();
    check("ovr", 9'h000, {8'h00, ovr});
    pop_chk();
    $display("overrun single done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
